// file: rtl/fbg_top.sv
// Contract
// - Modem control bit 7 divides the oscillator by 4 when set, else by 1.
// - The divisor runs from 1 to just under 65536 in sixteenth steps.
// - The divided output is the sample tick that paces shifting and sampling.
// - Reset sets divisor low 0x01, high 0x00, fraction 0x00: a divisor of one.
// - The two bytes form the integer divisor; the fraction register the rest.
// - The low four fraction bits give zero up to fifteen sixteenths.
// - Fraction register bits 5:4 pick 16X for 00, 8X for 01 and 4X for 10.
// - Bit rate is clock over prescaler over divisor over oversampling ratio.
// - At 8X with an odd fraction a bit period may jitter by one prescaled clock.
// - Each channel has its own generator and prescaler on the shared clock.
// - Register accesses complete without the oscillator enable running.
// - One bit period spans 16, 8 or 4 sample ticks by the selected ratio.
`timescale 1ns/10ps
module fbg_top
    import fbg_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
)
(
    input  wire logic                      SYS_CLK,
    input  wire logic                      RST,
    input  wire logic                      OSC_EN,
    input  wire logic [ADDR_W-1:0]         ADDR,
    input  wire logic [7:0]                WDATA,
    input  wire logic                      WR,
    input  wire logic                      RD,
    output logic [7:0]                     RDATA,
    output fbg_pkg::fbg_tick_t [CHANNELS-1:0] TICK
);
    import fbg_pkg::*;

    // One address bit selects the channel, so only two channels fit
    if (CHANNELS != NUM_CHANNELS) begin : gen_bad_channels
        $error("CHANNELS must match the channel select width");
    end

    logic [7:0] div_low_reg  [CHANNELS];
    logic [7:0] div_high_reg [CHANNELS];
    logic [7:0] div_frac_reg [CHANNELS];
    logic [7:0] modem_reg    [CHANNELS];
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] stat_seen_reg [CHANNELS];

    wire        ch_sel;
    wire [3:0]  ofs;
    wire [7:0]  rd_mux;

    assign ch_sel = ADDR[CH_BIT];
    assign ofs    = ADDR[3:0];

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : gen_ch
            fbg_cfg_t cfg;
            wire      sel;
            assign sel = (ch_sel == 1'(g));
            assign cfg.int_div   = {div_high_reg[g], div_low_reg[g]};
            assign cfg.frac_div  = div_frac_reg[g][FRAC_LSB +: FRAC_W];
            assign cfg.samp_mode =
                fbg_samp_t'(div_frac_reg[g][SAMP_LSB +: SAMP_W]);
            assign cfg.prescale4 = modem_reg[g][PRESCALE_BIT];

            // Bus logic runs on SYS_CLK alone; OSC_EN gates only the generator
            always_ff @(posedge SYS_CLK) begin
                if (RST) begin
                    div_low_reg[g]  <= RST_DIV_LOW;
                    div_high_reg[g] <= RST_DIV_HIGH;
                    div_frac_reg[g] <= RST_DIV_FRAC;
                    modem_reg[g]    <= RST_MODEM_CTL;
                end else if (WR && sel) begin
                    if (ofs == OFS_DIV_LOW) begin
                        div_low_reg[g] <= WDATA;
                    end
                    if (ofs == OFS_DIV_HIGH) begin
                        div_high_reg[g] <= WDATA;
                    end
                    if (ofs == OFS_DIV_FRAC) begin
                        div_frac_reg[g] <= {2'b00, WDATA[5:0]};
                    end
                    if (ofs == OFS_MODEM_CTL) begin
                        modem_reg[g] <= WDATA;
                    end
                end
            end

            // Sticky tick-seen flags; set wins over the clear from a read
            always_ff @(posedge SYS_CLK) begin
                if (RST) begin
                    stat_seen_reg[g] <= 8'h00;
                end else begin
                    stat_seen_reg[g] <= {6'h00,
                        TICK[g].bit_tick ||
                            (stat_seen_reg[g][1] &&
                             !(RD && sel && ofs == OFS_STATUS)),
                        TICK[g].sample_tick ||
                            (stat_seen_reg[g][0] &&
                             !(RD && sel && ofs == OFS_STATUS))};
                end
            end

            fbg_channel u_chan (
                .clk    (SYS_CLK),
                .rst    (RST),
                .osc_en (OSC_EN),
                .cfg    (cfg),
                .tick   (TICK[g])
            );
        end
    endgenerate

    assign rd_mux = (ofs == OFS_DIV_LOW)   ? div_low_reg[ch_sel]  :
                    (ofs == OFS_DIV_HIGH)  ? div_high_reg[ch_sel] :
                    (ofs == OFS_DIV_FRAC)  ? div_frac_reg[ch_sel] :
                    (ofs == OFS_MODEM_CTL) ? modem_reg[ch_sel]    :
                    (ofs == OFS_STATUS)    ? stat_seen_reg[ch_sel] :
                    8'h00;
    assign rdata_next = RD ? rd_mux : 8'h00;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign RDATA = rdata_reg;
endmodule

// file: rtl/fbg_pkg.sv
package fbg_pkg;

    localparam int NUM_CHANNELS = 2;

    // Register offsets on the plain register port
    localparam logic [3:0] OFS_DIV_LOW   = 4'h0;
    localparam logic [3:0] OFS_DIV_HIGH  = 4'h1;
    localparam logic [3:0] OFS_DIV_FRAC  = 4'h2;
    localparam logic [3:0] OFS_MODEM_CTL = 4'h3;
    localparam logic [3:0] OFS_STATUS    = 4'h4;

    // Channel select is the address bit above the register offset
    localparam int ADDR_W   = 5;
    localparam int CH_BIT   = 4;

    // Reset values
    localparam logic [7:0] RST_DIV_LOW   = 8'h01;
    localparam logic [7:0] RST_DIV_HIGH  = 8'h00;
    localparam logic [7:0] RST_DIV_FRAC  = 8'h00;
    localparam logic [7:0] RST_MODEM_CTL = 8'h00;

    // Field positions
    localparam int FRAC_LSB     = 0;
    localparam int FRAC_W       = 4;
    localparam int SAMP_LSB     = 4;
    localparam int SAMP_W       = 2;
    localparam int PRESCALE_BIT = 7;

    // Prescaler and fraction step figures
    localparam int PRESCALE_DIV = 4;
    localparam int FRAC_STEPS   = 16;

    typedef enum logic [1:0] {
        FBG_SAMP_16X = 2'b00,
        FBG_SAMP_8X  = 2'b01,
        FBG_SAMP_4X  = 2'b10,
        FBG_SAMP_RSV = 2'b11
    } fbg_samp_t;

    typedef struct packed {
        logic [15:0] int_div;
        logic [3:0]  frac_div;
        fbg_samp_t   samp_mode;
        logic        prescale4;
    } fbg_cfg_t;

    typedef struct packed {
        logic sample_tick;
        logic bit_tick;
    } fbg_tick_t;

endpackage

// file: rtl/fbg_channel.sv
`timescale 1ns/10ps
module fbg_channel
    import fbg_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic           osc_en,
    input  fbg_pkg::fbg_cfg_t   cfg,
    output fbg_pkg::fbg_tick_t  tick
);
    logic [1:0]  pre_cnt_reg;
    logic [1:0]  pre_cnt_next;
    logic [15:0] div_cnt_reg;
    logic [15:0] div_cnt_next;
    logic [3:0]  phase_reg;
    logic [3:0]  phase_next;
    logic [3:0]  bit_cnt_reg;
    logic [3:0]  bit_cnt_next;
    fbg_tick_t   tick_reg;
    fbg_tick_t   tick_next;

    wire         pre_last;
    wire         pre_tick;
    wire         stretch;
    wire [15:0]  period_top;
    wire         div_wrap;
    wire [3:0]   bit_last;
    wire         bit_wrap;

    assign pre_last     = !cfg.prescale4 ||
                          pre_cnt_reg == 2'(PRESCALE_DIV - 1);
    assign pre_tick     = osc_en && pre_last;
    assign pre_cnt_next = !osc_en ? pre_cnt_reg :
                          pre_last ? 2'h0 : pre_cnt_reg + 2'h1;

    // Bit-reversed phase spreads the extra cycles over sixteen ticks
    assign stretch    = ({phase_reg[0], phase_reg[1], phase_reg[2], phase_reg[3]}
                         < cfg.frac_div);
    assign period_top = (cfg.int_div == 16'h0000) ? 16'h0000 :
                        stretch ? cfg.int_div :
                        cfg.int_div - 16'h0001;
    assign div_wrap   = pre_tick && (div_cnt_reg >= period_top);
    assign div_cnt_next = !pre_tick ? div_cnt_reg :
                          div_wrap ? 16'h0000 : div_cnt_reg + 16'h0001;
    assign phase_next = div_wrap ? phase_reg + 4'h1 : phase_reg;

    assign bit_last = (cfg.samp_mode == FBG_SAMP_8X) ? 4'h7 :
                      (cfg.samp_mode == FBG_SAMP_4X) ? 4'h3 :
                      4'hf;
    assign bit_wrap = div_wrap && (bit_cnt_reg >= bit_last);
    assign bit_cnt_next = !div_wrap ? bit_cnt_reg :
                          bit_wrap ? 4'h0 : bit_cnt_reg + 4'h1;

    assign tick_next.sample_tick = div_wrap;
    assign tick_next.bit_tick    = bit_wrap;
    assign tick = tick_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_cnt_reg <= 2'h0;
            div_cnt_reg <= 16'h0000;
            phase_reg   <= 4'h0;
            bit_cnt_reg <= 4'h0;
            tick_reg    <= '0;
        end else begin
            pre_cnt_reg <= pre_cnt_next;
            div_cnt_reg <= div_cnt_next;
            phase_reg   <= phase_next;
            bit_cnt_reg <= bit_cnt_next;
            tick_reg    <= tick_next;
        end
    end
endmodule

// file: test/fbg_checker.sv
`timescale 1ns/10ps
module fbg_checker
    import fbg_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
)
(
    input wire logic                          SYS_CLK,
    input wire logic                          RST,
    input wire logic                          OSC_EN,
    input wire logic [ADDR_W-1:0]             ADDR,
    input wire logic [7:0]                    WDATA,
    input wire logic                          WR,
    input wire logic                          RD,
    input wire logic [7:0]                    RDATA,
    input wire fbg_pkg::fbg_tick_t [CHANNELS-1:0] TICK
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    rd_slot_a: assert property (RDATA != 8'h00 |-> $past(RD))
        else $error("read data outside slot");
    rst_quiet_a: assert property (
        $past(RST) |-> RDATA == 8'h00 && TICK == '0)
        else $error("outputs busy after reset");
    no_osc_a: assert property (
        !OSC_EN [*3] |-> !TICK[0].sample_tick && !TICK[1].sample_tick)
        else $error("tick without oscillator");
    bit_on0_a: assert property (TICK[0].bit_tick |-> TICK[0].sample_tick)
        else $error("bit tick off sample tick");
    bit_on1_a: assert property (TICK[1].bit_tick |-> TICK[1].sample_tick)
        else $error("bit tick off sample tick");
    bit_gap0_a: assert property (
        TICK[0].bit_tick |=> !TICK[0].bit_tick [*3])
        else $error("bit period too short");
    bit_gap1_a: assert property (
        TICK[1].bit_tick |=> !TICK[1].bit_tick [*3])
        else $error("bit period too short");
    frac_top_a: assert property (
        RD && ADDR[3:0] == OFS_DIV_FRAC |=> RDATA[7:6] == 2'b00)
        else $error("fraction top bits set");
    unmapped_a: assert property (
        RD && ADDR[3:0] > OFS_STATUS |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
endmodule

// file: test/fbg_top_tb.sv
`timescale 1ns/10ps
module fbg_top_tb;
    import fbg_pkg::*;
    logic                         clk;
    logic                         rst;
    logic                         osc_en;
    logic [ADDR_W-1:0]            addr;
    logic [7:0]                   wdata;
    logic                         wr;
    logic                         rd;
    logic [7:0]                   rdata;
    fbg_tick_t [NUM_CHANNELS-1:0] tick;
    int                           err_count;
    int                           samples_checked;

    fbg_top dut (.SYS_CLK(clk), .RST(rst), .OSC_EN(osc_en), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .TICK(tick));

    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rreg(input logic [4:0] a, input logic [7:0] e, string nm);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(nm, {8'h00, rdata}, {8'h00, e});
        @(posedge clk);
    endtask

    task automatic wait_bit(input bit c);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (tick[c].bit_tick !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            err_count++;
            conclude();
        end
    endtask

    // Sixteen sample periods span prescale * (16 * int + frac) clocks
    task automatic meas(input bit c, input logic [7:0] d, input logic [3:0] f,
                        input logic [1:0] m, input bit p);
        int cyc;
        int s;
        int b;
        cyc = 0;
        s = 0;
        b = 0;
        wreg({c, OFS_DIV_LOW}, d);
        wreg({c, OFS_DIV_HIGH}, 8'h00);
        wreg({c, OFS_DIV_FRAC}, {2'b00, m, f});
        wreg({c, OFS_MODEM_CTL}, {p, 7'h00});
        osc_en <= 1'b1;
        wait_bit(c);
        wait_bit(c);
        while (s < 16 && cyc < 5000) begin
            @(negedge clk);
            cyc++;
            s += int'(tick[c].sample_tick);
            b += int'(tick[c].bit_tick);
        end
        if (cyc >= 5000) begin
            err_count++;
            conclude();
        end
        chk("period", cyc[15:0],
            (p ? 16'd4 : 16'd1) * (16'd16 * d + f));
        chk("bits", b[15:0],
            m == 2'b01 ? 16'd2 : m == 2'b10 ? 16'd4 : 16'd1);
        @(posedge clk);
    endtask

    task automatic t_reset();
        for (int c = 0; c < 2; c++) begin
            rreg({c[0], OFS_DIV_LOW}, 8'h01, "low");
            rreg({c[0], OFS_DIV_HIGH}, 8'h00, "high");
            rreg({c[0], OFS_DIV_FRAC}, 8'h00, "frac");
            rreg({c[0], OFS_MODEM_CTL}, 8'h00, "modem");
        end
        $display("test reset done");
    endtask

    task automatic t_regs();
        wreg(5'h10, 8'h5a);
        wreg(5'h11, 8'ha5);
        wreg(5'h12, 8'hff);
        rreg(5'h10, 8'h5a, "low");
        rreg(5'h11, 8'ha5, "high");
        rreg(5'h12, 8'h3f, "frac");
        rreg(5'h00, 8'h01, "other");
        rreg(5'h07, 8'h00, "unmapped");
        rreg(5'h14, 8'h00, "idle status");
        $display("test registers done");
    endtask

    task automatic t_rate();
        meas(1'b0, 8'h01, 4'h0, 2'b00, 1'b0);
        meas(1'b1, 8'h03, 4'h5, 2'b01, 1'b0);
        meas(1'b0, 8'h02, 4'hf, 2'b10, 1'b1);
        meas(1'b1, 8'h02, 4'h0, 2'b11, 1'b1);
        $display("test rates done");
    endtask

    // Stop the oscillator, then the sticky flags read once and clear
    task automatic t_status();
        osc_en <= 1'b0;
        repeat (3) @(posedge clk);
        rreg({1'b0, OFS_STATUS}, 8'h03, "status");
        rreg({1'b0, OFS_STATUS}, 8'h00, "cleared");
        rreg({1'b1, OFS_STATUS}, 8'h03, "status other");
        $display("test status done");
    endtask

    task automatic t_midreset();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rreg({1'b1, OFS_DIV_LOW}, RST_DIV_LOW, "low again");
        rreg({1'b1, OFS_DIV_FRAC}, RST_DIV_FRAC, "frac again");
        rreg({1'b0, OFS_MODEM_CTL}, RST_MODEM_CTL, "modem again");
        $display("test mid-run reset done");
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        err_count = 0;
        samples_checked = 0;
        rst = 1'b1;
        osc_en = 1'b0;
        addr = '0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_regs();
        t_rate();
        t_status();
        t_midreset();
        conclude();
    end
endmodule

bind fbg_top fbg_checker #(.CHANNELS(CHANNELS)) u_chk (.SYS_CLK(SYS_CLK),
    .RST(RST), .OSC_EN(OSC_EN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .TICK(TICK));
